// [hw/mfp_channel.sv]
// One PWM channel: 8-bit fundamental wave plus 4-bit additional pulses.
// Assumes one unit tick pulse from the shared prescaler.
module mfp_channel
  import mfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic en,
  input wire logic tick,
  input wire mfp_chcfg_s cfg,
  output logic pin,
  output logic period_end,
  output logic [3:0] frame
);
  typedef struct packed {
    mfp_chcfg_s act;
    logic [7:0] cnt;
    logic [3:0] frame;
    logic pin;
    logic wrap;
  } mfp_ch_s;
  mfp_ch_s st_r, st_nxt;
  logic extra;
  logic [8:0] width;

  // Settings clamped to the legal ranges
  function automatic mfp_chcfg_s clamp(input mfp_chcfg_s c);
    mfp_chcfg_s r;
    r = c;
    if (r.per_m1 < MFP_PER_MIN) begin
      r.per_m1 = MFP_PER_MIN;
    end
    if (r.high > r.per_m1) begin
      r.high = r.per_m1;
    end
    return r;
  endfunction

  // ==========================================================
  // Period counter, frame counter and output compare
  always_comb begin
    st_nxt = st_r;
    st_nxt.wrap = 1'b0;
    if (!en) begin
      st_nxt.cnt = '0;
      st_nxt.frame = '0;
      st_nxt.act = clamp(cfg);
    end else if (tick) begin
      if (st_r.cnt == st_r.act.per_m1) begin
        st_nxt.cnt = '0;
        st_nxt.frame = st_r.frame + 1'b1;
        st_nxt.act = clamp(cfg);
        st_nxt.wrap = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
    // Bit-reversed frame index spreads the widened periods evenly
    extra = st_nxt.act.add_mode &&
      ({st_nxt.frame[0], st_nxt.frame[1], st_nxt.frame[2], st_nxt.frame[3]} < st_nxt.act.add);
    width = {1'b0, st_nxt.act.high} + {8'h00, extra};
    st_nxt.pin = en && ({1'b0, st_nxt.cnt} < width);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
      st_r.act.per_m1 <= MFP_PER_MIN;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign pin = st_r.pin;
  assign period_end = st_r.wrap;
  assign frame = st_r.frame;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  zero_low_a: assert property (st_r.act.high == 8'h00 && !st_r.act.add_mode |-> !st_r.pin)
    else $error("zero width did not give low output");
  last_low_a: assert property (!st_r.act.add_mode && st_r.cnt == st_r.act.per_m1 |-> !st_r.pin)
    else $error("plain mode high through the whole period");
  per_min_a: assert property (st_r.act.per_m1 >= MFP_PER_MIN && st_r.cnt <= st_r.act.per_m1)
    else $error("period below 16 units or counter overran");
  frame_wrap_a: assert property (en && tick && st_r.frame == MFP_FRAME_LAST
    && st_r.cnt == st_r.act.per_m1 |=> st_r.frame == 4'h0 && st_r.wrap)
    else $error("pattern did not repeat after sixteen periods");
  first_wide_a: assert property (en && st_r.act.add_mode && st_r.act.add != 4'h0
    && st_r.frame == 4'h0
    && st_r.cnt == st_r.act.high |-> st_r.pin)
    else $error("frame zero missed its extra unit");
endmodule

// [hw/mfp_pkg.sv]
// Shared constants, types and helpers for the two-channel multifrequency PWM.
// Assumes one system clock and an Avalon-MM slave port with byte addresses.
package mfp_pkg;
  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] MFP_OFS_CTRL = 8'h00;
  localparam logic [7:0] MFP_OFS_CFG_A = 8'h04;
  localparam logic [7:0] MFP_OFS_CFG_B = 8'h08;
  localparam logic [7:0] MFP_OFS_STATUS = 8'h0c;
  localparam logic [7:0] MFP_OFS_MASK = 8'h10;
  localparam logic [7:0] MFP_OFS_STATE = 8'h14;
  // ==========================================================
  // Field positions and writable bits
  localparam int unsigned MFP_CTRL_EN = 0;
  localparam int unsigned MFP_CTRL_SRC = 1;
  localparam int unsigned MFP_CTRL_PRE = 8;
  localparam logic [31:0] MFP_CTRL_WMASK = 32'h0000_ff03;
  localparam logic [31:0] MFP_CFG_WMASK = 32'h010f_ffff;
  localparam logic [31:0] MFP_CFG_RST = 32'h0000_00ff;
  localparam int unsigned MFP_CFG_MODE = 24;
  localparam logic [1:0] MFP_EV_WMASK = 2'h3;
  // ==========================================================
  // Waveform limits
  localparam logic [7:0] MFP_PER_MIN = 8'h0f;
  localparam logic [3:0] MFP_FRAME_LAST = 4'hf;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MFP_BUS_IDLE = 2'b01,
    MFP_BUS_ACK = 2'b10
  } mfp_bus_e;
  typedef struct packed {
    logic add_mode;
    logic [3:0] add;
    logic [7:0] high;
    logic [7:0] per_m1;
  } mfp_chcfg_s;
  // Merge write data into a word under byte enables
  function automatic logic [31:0] mfp_bemerge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction
endpackage

// [hw/mfp_prescaler.sv]
// Shared prescaler: divides the chosen source into the basic time unit.
// Assumes the oscillator input is already synchronous to clk_sys.
module mfp_prescaler
  import mfp_pkg::*;
#(
  parameter int PRE_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic en,
  input wire logic src_osc,
  input wire logic osc_in,
  input wire logic [PRE_W-1:0] pre,
  output logic tick
);
  typedef struct packed {
    logic osc_q;
    logic [PRE_W-1:0] cnt;
    logic tick;
  } mfp_pre_s;
  mfp_pre_s st_r, st_nxt;
  logic src_tick;

  // ==========================================================
  // Source pick and divide by pre+1
  always_comb begin
    st_nxt = st_r;
    st_nxt.osc_q = osc_in;
    st_nxt.tick = 1'b0;
    src_tick = src_osc ? (osc_in && !st_r.osc_q) : 1'b1;
    if (!en) begin
      st_nxt.cnt = '0;
    end else if (src_tick) begin
      if (st_r.cnt == pre) begin
        st_nxt.cnt = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign tick = st_r.tick;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles since last tick, for the spacing check
  logic [PRE_W:0] gap_r;
  logic seen_r;
  // Spacing is only judged between two ticks under one unchanged setting
  always_ff @(posedge clk_sys) begin
    if (rst || !en || src_osc || pre != $past(pre)) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (st_r.tick) begin
      gap_r <= '0;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 1'b1;
    end
  end
  tick_gap_a: assert property (en && !src_osc && seen_r && $stable(pre) && st_r.tick
    |-> gap_r == {1'b0, pre}) else $error("unit tick spacing wrong");
  osc_only_a: assert property (en && src_osc && !(osc_in && !st_r.osc_q) |=> $stable(st_r.cnt))
    else $error("prescaler moved without oscillator edge");
endmodule

// [hw/mfp_top.sv]
// Top of the two-channel multifrequency PWM with its Avalon-MM register port.
// Assumes one clock, synchronous reset and an oscillator input that is
// already synchronous to clk_sys.
//
// Added by the designer: register access over Avalon-MM and the address map.
import mfp_pkg::*;

// How it works
// - Channels A and B hold their own period, width and mode and never disturb each other.
// - The prescaler counts either every system clock or each main oscillator rising edge.
// - The basic time unit equals the prescaler value plus one source clock periods.
// - Each channel joins an 8-bit fundamental wave with a 4-bit additional pulse count.
// - The fundamental period is settable from 16 to 256 units in both modes.
// - The high width runs from zero, which is steady low in plain mode, up to the period minus one unit.
// - A mode bit chooses plain fundamental wave or fundamental plus additional pulses.
// - With additional pulses the whole pattern repeats every sixteen periods.
// - The unit drives two outputs, A and B, with 12-bit effective resolution.
// - The unit raises exactly one interrupt line.
module mfp_top #(
  parameter int PRE_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic main_ceramic_oscillator,
  output logic pwm_output_a,
  output logic pwm_output_b,
  output logic irq
);
  // ==========================================================
  // Elaboration check
  if (PRE_W < 1 || PRE_W > 8) begin : g_bad_pre
    $error("PRE_W must lie between 1 and 8");
  end

  // ==========================================================
  // Block state
  typedef struct packed {
    mfp_bus_e bus;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] cfg_a;
    logic [31:0] cfg_b;
    logic [1:0] status;
    logic [1:0] mask;
  } mfp_top_s;
  mfp_top_s st_r, st_nxt;

  logic en;
  logic src_osc;
  logic [PRE_W-1:0] pre;
  logic unit_tick;
  logic pin_a, pin_b;
  logic end_a, end_b;
  logic [3:0] frame_a, frame_b;
  logic [31:0] rd_word;
  logic [1:0] ev;
  logic [1:0] clr;

  // Unpack a stored channel word into its settings
  function automatic mfp_chcfg_s to_cfg(input logic [31:0] w);
    mfp_chcfg_s c;
    // Mode bit sits apart from the packed count, width and period fields
    c = mfp_chcfg_s'({w[MFP_CFG_MODE], w[$bits(mfp_chcfg_s)-2:0]});
    return c;
  endfunction

  // ==========================================================
  // Control fields
  assign en = st_r.ctrl[MFP_CTRL_EN];
  assign src_osc = st_r.ctrl[MFP_CTRL_SRC];
  assign pre = st_r.ctrl[MFP_CTRL_PRE +: PRE_W];

  // ==========================================================
  // Shared time base and the two channels
  mfp_prescaler #(
    .PRE_W(PRE_W)
  ) u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .en(en),
    .src_osc(src_osc),
    .osc_in(main_ceramic_oscillator),
    .pre(pre),
    .tick(unit_tick)
  );

  // Channel A, own settings word
  mfp_channel u_ch_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .en(en),
    .tick(unit_tick),
    .cfg(to_cfg(st_r.cfg_a)),
    .pin(pin_a),
    .period_end(end_a),
    .frame(frame_a)
  );

  // Channel B, own settings word
  mfp_channel u_ch_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .en(en),
    .tick(unit_tick),
    .cfg(to_cfg(st_r.cfg_b)),
    .pin(pin_b),
    .period_end(end_b),
    .frame(frame_b)
  );

  // Two named outputs
  assign pwm_output_a = pin_a;
  assign pwm_output_b = pin_b;

  // ==========================================================
  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    if (avs_address == MFP_OFS_CTRL) begin
      rd_word = st_r.ctrl;
    end else if (avs_address == MFP_OFS_CFG_A) begin
      rd_word = st_r.cfg_a;
    end else if (avs_address == MFP_OFS_CFG_B) begin
      rd_word = st_r.cfg_b;
    end else if (avs_address == MFP_OFS_STATUS) begin
      rd_word = {30'h0000_0000, st_r.status};
    end else if (avs_address == MFP_OFS_MASK) begin
      rd_word = {30'h0000_0000, st_r.mask};
    end else if (avs_address == MFP_OFS_STATE) begin
      rd_word = {20'h0_0000, frame_b, frame_a, 2'h0, pin_b, pin_a};
    end
  end

  // ==========================================================
  // Bus handshake, register writes and event flags
  always_comb begin
    st_nxt = st_r;
    ev = {end_b, end_a};
    clr = 2'h0;
    case (st_r.bus)
      MFP_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_nxt.bus = MFP_BUS_ACK;
          st_nxt.rdata = avs_read ? rd_word : 32'h0000_0000;
        end
      end
      MFP_BUS_ACK: begin
        st_nxt.bus = MFP_BUS_IDLE;
        if (avs_write) begin
          if (avs_address == MFP_OFS_CTRL) begin
            st_nxt.ctrl = mfp_bemerge(st_r.ctrl, avs_writedata, avs_byteenable)
              & MFP_CTRL_WMASK;
          end else if (avs_address == MFP_OFS_CFG_A) begin
            st_nxt.cfg_a = mfp_bemerge(st_r.cfg_a, avs_writedata, avs_byteenable)
              & MFP_CFG_WMASK;
          end else if (avs_address == MFP_OFS_CFG_B) begin
            st_nxt.cfg_b = mfp_bemerge(st_r.cfg_b, avs_writedata, avs_byteenable)
              & MFP_CFG_WMASK;
          end else if (avs_address == MFP_OFS_STATUS) begin
            if (avs_byteenable[0]) begin
              clr = avs_writedata[1:0] & MFP_EV_WMASK;
            end
          end else if (avs_address == MFP_OFS_MASK) begin
            if (avs_byteenable[0]) begin
              st_nxt.mask = avs_writedata[1:0] & MFP_EV_WMASK;
            end
          end
        end
      end
      default: begin
        st_nxt.bus = MFP_BUS_IDLE;
      end
    endcase
    // A new period end beats a clear in the same cycle
    st_nxt.status = (st_r.status & ~clr) | ev;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
      st_r.bus <= MFP_BUS_IDLE;
      st_r.cfg_a <= MFP_CFG_RST;
      st_r.cfg_b <= MFP_CFG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_waitrequest = (avs_read || avs_write) && (st_r.bus == MFP_BUS_IDLE);
  assign avs_readdata = st_r.rdata;
  assign irq = |(st_r.status & st_r.mask);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // A request seen while the port is idle
  sequence bus_req_s;
    (avs_read || avs_write) && st_r.bus == MFP_BUS_IDLE;
  endsequence

  // The same request answered on the next cycle
  sequence bus_done_s;
    !avs_waitrequest && st_r.bus == MFP_BUS_ACK;
  endsequence

  bus_answer_a: assert property (bus_req_s |-> avs_waitrequest ##1 bus_done_s)
    else $error("bus request not answered on the second cycle");

  stat_set_a: assert property (end_a |=> st_r.status[0])
    else $error("channel A period end lost");

  stat_set_b_a: assert property (end_b |=> st_r.status[1])
    else $error("channel B period end lost");

  irq_level_a: assert property (st_r.status[0] && st_r.mask[0] |-> irq)
    else $error("unmasked event did not raise the interrupt");

  irq_quiet_a: assert property (st_r.mask == 2'h0 |-> !irq)
    else $error("interrupt raised while all sources masked");

  indep_b_a: assert property (avs_write && st_r.bus == MFP_BUS_ACK
    && avs_address == MFP_OFS_CFG_A |=> $stable(st_r.cfg_b))
    else $error("write to channel A changed channel B");

  indep_a_a: assert property (avs_write && st_r.bus == MFP_BUS_ACK
    && avs_address == MFP_OFS_CFG_B |=> $stable(st_r.cfg_a))
    else $error("write to channel B changed channel A");

  off_low_a: assert property (!en |=> !pwm_output_a && !pwm_output_b)
    else $error("outputs high while the unit is stopped");

  src_sys_a: assert property (en && !src_osc && pre == '0 && u_pre.st_r.cnt == '0
    |=> unit_tick)
    else $error("system clock source with zero prescale did not tick every cycle");
endmodule

// [test/mfp_load.sv]
// Observer load on the two PWM outputs: measures each pulse and period.
// Assumes registered outputs on clk_sys; all counts are in clk_sys cycles.
module mfp_load (
  input wire logic clk_sys,
  input wire logic [1:0] pin,
  output int hi_n[2],
  output int per_n[2],
  output int rises[2]
);
  timeunit 1ns;
  timeprecision 1ps;
  int hc[2];
  int pc[2];
  logic [1:0] prev_r = 2'h0;
  // ==========================================================
  // Pulse measurement, closed at each rising edge of an output
  always @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (pin[i] === 1'b1 && prev_r[i] === 1'b0) begin
        per_n[i] <= pc[i];
        hi_n[i] <= hc[i];
        rises[i] <= rises[i] + 1;
        pc[i] <= 1;
        hc[i] <= 1;
      end else begin
        pc[i] <= pc[i] + 1;
        hc[i] <= hc[i] + ((pin[i] === 1'b1) ? 1 : 0);
      end
    end
    prev_r <= pin;
  end
endmodule

// [test/tb.sv]
// Self-checking bench for the two-channel PWM: registers, waveforms, interrupt.
// Assumes mfp_pkg, the design files and the mfp_load observer compile first.
module tb
  import mfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic osc = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wreq;
  logic pa;
  logic pb;
  logic irq;
  int hi_n[2];
  int per_n[2];
  int rises[2];
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h49bd_d94b;
  int w[32];
  int tp[3] = '{3, 255, 15};
  int th[3] = '{20, 255, 1};
  int ep[3] = '{16, 256, 16};
  int eh[3] = '{15, 255, 1};

  // ==========================================================
  // Design and observer load
  mfp_top #(.PRE_W(8)) mfp_top_i (
    .clk_sys(clk_sys), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .main_ceramic_oscillator(osc), .pwm_output_a(pa),
    .pwm_output_b(pb), .irq(irq)
  );
  mfp_load mfp_load_i (
    .clk_sys(clk_sys), .pin({pb, pa}), .hi_n(hi_n), .per_n(per_n), .rises(rises)
  );

  // ==========================================================
  // Clock, oscillator of six system cycles, watchdog
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    forever begin
      repeat (3) @(posedge clk_sys);
      osc <= ~osc;
    end
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end

  // ==========================================================
  // Checking, reporting and reference model
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // High units of one period: extra unit where the reversed frame index is below the count
  function automatic int exp_w(int a, int m, int f);
    int rv;
    rv = (f & 1) * 8 + (f & 2) * 2 + (f & 4) / 2 + (f & 8) / 8;
    return 4 + ((m == 1 && rv < a) ? 1 : 0);
  endfunction
  function automatic logic [31:0] cfgw(int m, int a, int h, int p);
    return (32'(m) << 24) | (32'(a) << 16) | (32'(h) << 8) | 32'(p);
  endfunction

  // ==========================================================
  // Bus master: holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] dq);
    int k;
    k = 0;
    wr <= w;
    rd <= ~w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    dq = rdata;
    if (k >= 50) n_fail++;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dq;
    bus(1'b1, a, d, dq);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dq;
    bus(1'b0, a, 32'h0000_0000, dq);
    chk(dq, e);
  endtask
  // Waits for a number of rising edges on one output, bounded
  task automatic rise(input int ch, input int cnt);
    int r0;
    int k;
    r0 = rises[ch];
    k = 0;
    while (rises[ch] - r0 < cnt && k < 20000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 20000) n_fail++;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int ok;
    int k;
    int pre;
    int ha;
    int hb;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values, byte enables, write masks and an unmapped place
    rdc(MFP_OFS_CTRL, 32'h0000_0000);
    rdc(MFP_OFS_CFG_A, MFP_CFG_RST);
    rdc(MFP_OFS_CFG_B, MFP_CFG_RST);
    rdc(MFP_OFS_STATUS, 32'h0000_0000);
    rdc(MFP_OFS_MASK, 32'h0000_0000);
    wr32(8'h18, 32'hffff_ffff);
    rdc(8'h18, 32'h0000_0000);
    be <= 4'h1;
    wr32(MFP_OFS_CTRL, 32'hffff_ffff);
    be <= 4'hf;
    rdc(MFP_OFS_CTRL, 32'h0000_0003);
    wr32(MFP_OFS_CTRL, 32'hffff_ffff);
    rdc(MFP_OFS_CTRL, MFP_CTRL_WMASK);
    // Plain mode, random prescale and widths, channels changed apart
    for (int n = 0; n < 3; n++) begin
      pre = $unsigned($random(seed)) % 4;
      ha = 1 + $unsigned($random(seed)) % 14;
      hb = 1 + $unsigned($random(seed)) % 30;
      wr32(MFP_OFS_CTRL, (32'(pre) << 8) | 32'h0000_0001);
      wr32(MFP_OFS_CFG_A, cfgw(0, 0, ha, 15));
      wr32(MFP_OFS_CFG_B, cfgw(0, 0, hb, 31));
      rise(0, 3);
      rise(1, 2);
      chk(per_n[0], 16 * (pre + 1));
      chk(hi_n[0], ha * (pre + 1));
      chk(per_n[1], 32 * (pre + 1));
      chk(hi_n[1], hb * (pre + 1));
      wr32(MFP_OFS_CFG_B, cfgw(0, 0, 31 - hb, 31));
      rise(0, 3);
      chk(hi_n[0], ha * (pre + 1));
    end
    // Boundary periods and widths, clamped settings among them
    wr32(MFP_OFS_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr32(MFP_OFS_CFG_A, cfgw(0, 0, th[i], tp[i]));
      rise(0, 3);
      chk(per_n[0], ep[i]);
      chk(hi_n[0], eh[i]);
    end
    // Zero width keeps the output low
    wr32(MFP_OFS_CFG_B, cfgw(0, 0, 0, 15));
    rise(0, 4);
    k = 0;
    repeat (40) begin
      @(posedge clk_sys);
      k += (pb !== 1'b0) ? 1 : 0;
    end
    chk(k, 0);
    // Oscillator source, prescale 1: one unit is two oscillator periods
    wr32(MFP_OFS_CTRL, 32'h0000_0103);
    wr32(MFP_OFS_CFG_A, cfgw(0, 0, 3, 15));
    rise(0, 3);
    chk(per_n[0], 16 * 12);
    chk(hi_n[0], 3 * 12);
    // Additional-pulse pattern for every count, in both modes
    wr32(MFP_OFS_CTRL, 32'h0000_0001);
    for (int m = 0; m < 2; m++) begin
      for (int a = 0; a < 16; a++) begin
        wr32(MFP_OFS_CFG_A, cfgw(m, a, 4, 15));
        rise(0, 3);
        for (int i = 0; i < 32; i++) begin
          rise(0, 1);
          w[i] = hi_n[0];
        end
        ok = 0;
        for (int ph = 0; ph < 16; ph++) begin
          k = 1;
          for (int i = 0; i < 32; i++) begin
            if (w[i] != exp_w(a, m, (i + ph) % 16)) k = 0;
          end
          ok |= k;
        end
        chk(ok, 1);
        for (int i = 0; i < 16; i++) chk(w[i], w[i + 16]);
      end
    end
    // Sticky period-end events, masking and write-one-to-clear
    rise(0, 2);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0);
    bus(1'b0, MFP_OFS_STATUS, 32'h0000_0000, q);
    chk(q[0], 1'b1);
    wr32(MFP_OFS_MASK, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b1);
    wr32(MFP_OFS_CTRL, 32'h0000_0000);
    wr32(MFP_OFS_STATUS, 32'h0000_0000);
    rdc(MFP_OFS_STATE, 32'h0000_0000);
    rdc(MFP_OFS_STATUS, 32'h0000_0003);
    wr32(MFP_OFS_STATUS, 32'h0000_0001);
    rdc(MFP_OFS_STATUS, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0);
    final_report();
  end
endmodule
